// *** logic/flash_host_pkg.sv ***
package flash_host_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_ACC_NS = 70;
  localparam int T_WP_NS = 35;
  localparam int T_RP_NS = 500;
  localparam int T_REC_NS = 20;
  // Least times, rounded up to whole cycles.
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC = (T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 3;

  // ****************************************************************
  // Software register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_PROT = 8'h18;
  localparam int CTRL_GRP_LSB = 8;
  localparam int CFG_BYTE = 0;
  localparam int CFG_AUTO_RST = 1;
  localparam int CFG_PROG = 2;
  localparam int CFG_CODE_LSB = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_LIMIT = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_DONE = 3;
  localparam logic [6:0] CFG_RESET = 7'h00;
  localparam logic [15:0] RESET_CMD_DEFAULT = 16'h00f0;
  localparam int LIMIT_BIT = 5;
  localparam int PROT_BIT = 0;
  localparam int GROUPS = 24;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    op_read, op_write, op_hw_reset, op_autoselect, op_verify, op_protect, op_unprotect
  } op_e;
  typedef enum logic [1:0] {st_idle, st_active, st_recover} state_e;
  typedef struct packed {
    logic [20:0] addr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic byte_n;
    logic hv_a9;
    logic hv_reset;
    logic hv_oe;
  } pins_s;

endpackage : flash_host_pkg

// *** logic/group_addr_decode.sv ***
`timescale 1ns/1ps
module group_addr_decode #(
  parameter bit TOP_BOOT = 1'b1
) (
  input wire logic [4:0] group_i,
  output logic [8:0] sector_bits_o
);

  // ****************************************************************
  // Protection group to upper address bits
  // ****************************************************************
  logic [4:0] rel;

  // Only the first sector of each group is produced; the device treats the group as one unit.
  always_comb begin
    rel = 5'h00;
    if (TOP_BOOT) begin
      if (group_i < 5'h0f) begin
        sector_bits_o = {group_i[3:0], 5'h00};
      end else if (group_i == 5'h0f) begin
        sector_bits_o = 9'h1e0;
      end else begin
        rel = group_i - 5'h10;
        sector_bits_o = {6'h3f, rel[2:0]};
      end
    end else begin
      if (group_i < 5'h08) begin
        sector_bits_o = {6'h00, group_i[2:0]};
      end else if (group_i == 5'h08) begin
        sector_bits_o = 9'h008;
      end else begin
        rel = group_i - 5'h08;
        sector_bits_o = {rel[3:0], 5'h00};
      end
    end
  end

endmodule : group_addr_decode

// *** logic/flash_host.sv ***
// Behaviour
// - Host writes reset command after limit flag.
// - High-voltage autoselect: address_bit_nine high, code bits set.
// - Verify puts group address on top bits.
// - Write cycle: write and select low, output high.
// - In-system protect with reset at high voltage.
// - Protect all groups before chip unprotect.
// - Programmer method: high voltage on output, address_bit_nine.
`timescale 1ns/1ps
module flash_host #(
  parameter bit TOP_BOOT = 1'b1,
  parameter logic [15:0] RESET_CMD = flash_host_pkg::RESET_CMD_DEFAULT
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [7:0] sw_addr_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [31:0] sw_rdata_o,
  output flash_host_pkg::pins_s pins_o,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic [15:0] dq_oe_n_o
);

  // ****************************************************************
  // Declarations and helpers
  // ****************************************************************
  flash_host_pkg::state_e state_ff;
  flash_host_pkg::op_e op_ff;
  flash_host_pkg::op_e req_op;
  flash_host_pkg::pins_s nxt_pins;
  logic [7:0] cnt_ff;
  logic [4:0] grp_ff;
  logic [21:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [15:0] drive_ff;
  logic [6:0] cfg_ff;
  logic [23:0] prot_ff;
  logic [15:0] rd_ff;
  logic limit_ff, refused_ff, done_ff, rst_pend_ff;
  logic [15:0] dq_s1_ff, dq_s2_ff, dq_s3_ff;
  logic [15:0] nxt_dq, nxt_dq_oe_n;
  logic [8:0] grp_bits;
  logic ctrl_wr, legal, launch, auto_launch, capture, finish, byte_mode;

  function automatic logic is_read_op(flash_host_pkg::op_e op);
    return op == flash_host_pkg::op_read || op == flash_host_pkg::op_autoselect || op == flash_host_pkg::op_verify;
  endfunction : is_read_op

  function automatic logic is_write_op(flash_host_pkg::op_e op);
    return op == flash_host_pkg::op_write || op == flash_host_pkg::op_protect || op == flash_host_pkg::op_unprotect;
  endfunction : is_write_op

  function automatic logic [7:0] phase_len(flash_host_pkg::op_e op);
    if (is_read_op(op)) begin
      return 8'(flash_host_pkg::ACC_CYC + flash_host_pkg::SYNC_CYC + 1);
    end else if (op == flash_host_pkg::op_hw_reset) begin
      return 8'(flash_host_pkg::RP_CYC);
    end
    return 8'(flash_host_pkg::WP_CYC);
  endfunction : phase_len

  group_addr_decode #(.TOP_BOOT(TOP_BOOT)) u_decode (
    .group_i(grp_ff),
    .sector_bits_o(grp_bits)
  );

  // ****************************************************************
  // Request acceptance
  // ****************************************************************
  // A chip unprotect is refused until every group reads back as protected.
  assign byte_mode = cfg_ff[flash_host_pkg::CFG_BYTE];
  assign req_op = flash_host_pkg::op_e'(sw_wdata_i[2:0]);
  assign ctrl_wr = sw_wr_i && sw_addr_i == flash_host_pkg::REG_CTRL;
  assign legal = state_ff == flash_host_pkg::st_idle && !rst_pend_ff && sw_wdata_i[2:0] != 3'h7
                 && sw_wdata_i[flash_host_pkg::CTRL_GRP_LSB +: 5] < 5'(flash_host_pkg::GROUPS)
                 && (req_op != flash_host_pkg::op_unprotect || &prot_ff);
  assign launch = ctrl_wr && legal;
  assign auto_launch = state_ff == flash_host_pkg::st_idle && rst_pend_ff;
  // Floating upper pins in byte mode never settle, so only the low byte is waited on there.
  assign capture = state_ff == flash_host_pkg::st_active && cnt_ff == 8'h00 && is_read_op(op_ff)
                   && (byte_mode ? dq_s2_ff[7:0] == dq_s3_ff[7:0] : dq_s2_ff == dq_s3_ff);
  assign finish = state_ff == flash_host_pkg::st_recover && cnt_ff == 8'h00;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Reads stay in the active phase until two synchroniser stages agree, so a slow bus settles first.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_ff <= flash_host_pkg::st_idle;
      op_ff <= flash_host_pkg::op_read;
      cnt_ff <= 8'h00;
      grp_ff <= 5'h00;
      drive_ff <= 16'h0000;
    end else begin
      case (state_ff)
        flash_host_pkg::st_idle: begin
          if (auto_launch) begin
            op_ff <= flash_host_pkg::op_write;
            drive_ff <= RESET_CMD;
            cnt_ff <= phase_len(flash_host_pkg::op_write);
            state_ff <= flash_host_pkg::st_active;
          end else if (launch) begin
            op_ff <= req_op;
            grp_ff <= sw_wdata_i[flash_host_pkg::CTRL_GRP_LSB +: 5];
            drive_ff <= wdata_ff;
            cnt_ff <= phase_len(req_op);
            state_ff <= flash_host_pkg::st_active;
          end
        end
        flash_host_pkg::st_active: begin
          if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else if (!is_read_op(op_ff) || capture) begin
            cnt_ff <= 8'(flash_host_pkg::REC_CYC - 1);
            state_ff <= flash_host_pkg::st_recover;
          end
        end
        flash_host_pkg::st_recover: begin
          if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else begin
            state_ff <= flash_host_pkg::st_idle;
          end
        end
        default: begin
          state_ff <= flash_host_pkg::st_idle;
        end
      endcase
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Strobes are computed from the state and registered, so every pin leaves a flip-flop.
  always_comb begin
    nxt_pins = '0;
    nxt_pins.ce_n = 1'b1;
    nxt_pins.oe_n = 1'b1;
    nxt_pins.we_n = 1'b1;
    nxt_pins.reset_n = 1'b1;
    nxt_pins.byte_n = !byte_mode;
    nxt_pins.addr = byte_mode ? addr_ff[21:1] : addr_ff[20:0];
    nxt_dq = drive_ff;
    nxt_dq_oe_n = 16'hffff;
    if (state_ff != flash_host_pkg::st_idle) begin
      if (op_ff == flash_host_pkg::op_autoselect) begin
        nxt_pins.hv_a9 = 1'b1;
        nxt_pins.addr[6] = cfg_ff[flash_host_pkg::CFG_CODE_LSB + 2];
        nxt_pins.addr[1] = cfg_ff[flash_host_pkg::CFG_CODE_LSB + 1];
        nxt_pins.addr[0] = cfg_ff[flash_host_pkg::CFG_CODE_LSB];
      end
      if (op_ff == flash_host_pkg::op_verify || op_ff == flash_host_pkg::op_protect
          || op_ff == flash_host_pkg::op_unprotect) begin
        nxt_pins.addr = {grp_bits, 5'h00, op_ff == flash_host_pkg::op_unprotect, 4'h0, 2'b10};
      end
      if (op_ff == flash_host_pkg::op_verify) begin
        nxt_pins.hv_a9 = 1'b1;
      end
      if (op_ff == flash_host_pkg::op_protect || op_ff == flash_host_pkg::op_unprotect) begin
        nxt_pins.hv_reset = !cfg_ff[flash_host_pkg::CFG_PROG];
        nxt_pins.hv_a9 = cfg_ff[flash_host_pkg::CFG_PROG];
        nxt_pins.hv_oe = cfg_ff[flash_host_pkg::CFG_PROG];
      end
      if (is_read_op(op_ff)) begin
        nxt_pins.ce_n = 1'b0;
        nxt_pins.oe_n = state_ff != flash_host_pkg::st_active;
      end else if (is_write_op(op_ff)) begin
        nxt_pins.ce_n = 1'b0;
        nxt_pins.we_n = state_ff != flash_host_pkg::st_active;
        nxt_dq_oe_n = byte_mode ? 16'hff00 : 16'h0000;
      end else begin
        nxt_pins.reset_n = state_ff != flash_host_pkg::st_active;
      end
    end
    if (byte_mode) begin
      nxt_dq[15] = addr_ff[0];
      nxt_dq_oe_n[15] = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pins_o <= '{addr: 21'h00_0000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1, byte_n: 1'b1,
                  hv_a9: 1'b0, hv_reset: 1'b0, hv_oe: 1'b0};
      dq_o <= 16'h0000;
      dq_oe_n_o <= 16'hffff;
    end else begin
      pins_o <= nxt_pins;
      dq_o <= nxt_dq;
      dq_oe_n_o <= nxt_dq_oe_n;
    end
  end

  // ****************************************************************
  // Data capture
  // ****************************************************************
  // The data bus comes from outside the clock, so three stages guard it.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      dq_s1_ff <= 16'h0000;
      dq_s2_ff <= 16'h0000;
      dq_s3_ff <= 16'h0000;
    end else begin
      dq_s1_ff <= dq_i;
      dq_s2_ff <= dq_s1_ff;
      dq_s3_ff <= dq_s2_ff;
    end
  end

  // Verify results build the protection map; a chip unprotect clears it all.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rd_ff <= 16'h0000;
      prot_ff <= 24'h00_0000;
      rst_pend_ff <= 1'b0;
    end else begin
      if (capture) begin
        rd_ff <= byte_mode ? {8'h00, dq_s3_ff[7:0]} : dq_s3_ff;
        if (op_ff == flash_host_pkg::op_verify) begin
          prot_ff[grp_ff] <= dq_s3_ff[flash_host_pkg::PROT_BIT];
        end
      end
      if (finish && op_ff == flash_host_pkg::op_unprotect) begin
        prot_ff <= 24'h00_0000;
      end
      if (capture && op_ff == flash_host_pkg::op_read && dq_s3_ff[flash_host_pkg::LIMIT_BIT]
          && cfg_ff[flash_host_pkg::CFG_AUTO_RST]) begin
        rst_pend_ff <= 1'b1;
      end else if (auto_launch) begin
        rst_pend_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  // Sticky flags clear on a one written to them; a new event in that cycle wins.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      addr_ff <= 22'h00_0000;
      wdata_ff <= 16'h0000;
      cfg_ff <= flash_host_pkg::CFG_RESET;
      limit_ff <= 1'b0;
      refused_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      if (sw_wr_i && sw_addr_i == flash_host_pkg::REG_ADDR) begin
        addr_ff <= sw_wdata_i[21:0];
      end
      if (sw_wr_i && sw_addr_i == flash_host_pkg::REG_WDATA) begin
        wdata_ff <= sw_wdata_i[15:0];
      end
      if (sw_wr_i && sw_addr_i == flash_host_pkg::REG_CFG) begin
        cfg_ff <= sw_wdata_i[6:0];
      end
      if (capture && op_ff == flash_host_pkg::op_read && dq_s3_ff[flash_host_pkg::LIMIT_BIT]) begin
        limit_ff <= 1'b1;
      end else if (sw_wr_i && sw_addr_i == flash_host_pkg::REG_STATUS && sw_wdata_i[flash_host_pkg::ST_LIMIT]) begin
        limit_ff <= 1'b0;
      end
      if (ctrl_wr && !legal) begin
        refused_ff <= 1'b1;
      end else if (sw_wr_i && sw_addr_i == flash_host_pkg::REG_STATUS
                   && sw_wdata_i[flash_host_pkg::ST_REFUSED]) begin
        refused_ff <= 1'b0;
      end
      if (finish) begin
        done_ff <= 1'b1;
      end else if (sw_wr_i && sw_addr_i == flash_host_pkg::REG_STATUS && sw_wdata_i[flash_host_pkg::ST_DONE]) begin
        done_ff <= 1'b0;
      end
    end
  end

  // Read data stands in the cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sw_rdata_o <= 32'h0000_0000;
    end else if (sw_rd_i) begin
      case (sw_addr_i)
        flash_host_pkg::REG_ADDR: sw_rdata_o <= {10'h000, addr_ff};
        flash_host_pkg::REG_WDATA: sw_rdata_o <= {16'h0000, wdata_ff};
        flash_host_pkg::REG_CFG: sw_rdata_o <= {25'h000_0000, cfg_ff};
        flash_host_pkg::REG_STATUS: sw_rdata_o <= {28'h000_0000, done_ff, refused_ff, limit_ff,
                                                   state_ff != flash_host_pkg::st_idle || rst_pend_ff};
        flash_host_pkg::REG_RDATA: sw_rdata_o <= {16'h0000, rd_ff};
        flash_host_pkg::REG_PROT: sw_rdata_o <= {8'h00, prot_ff};
        default: sw_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      sw_rdata_o <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [7:0] low_cnt_ff;
  always_ff @(posedge clock_i) begin
    if (reset_i || pins_o.reset_n) begin
      low_cnt_ff <= 8'h00;
    end else if (low_cnt_ff != 8'hff) begin
      low_cnt_ff <= low_cnt_ff + 8'h01;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  a_write_cycle_pins: assert property (!pins_o.we_n |-> !pins_o.ce_n && pins_o.oe_n)
    else $error("write strobe without select low and output high");
  a_read_no_drive: assert property (!pins_o.oe_n |-> &dq_oe_n_o[14:0])
    else $error("host drives data while device outputs");
  a_deselect_no_drive: assert property (pins_o.ce_n |-> &dq_oe_n_o[14:0])
    else $error("host drives data while deselected");
  a_reset_pulse_width: assert property ($rose(pins_o.reset_n) |-> $past(low_cnt_ff) >= 8'(flash_host_pkg::RP_CYC))
    else $error("reset pulse too short");
  a_autoselect_code: assert property (op_ff == flash_host_pkg::op_autoselect && !pins_o.oe_n
    |-> pins_o.hv_a9 && {pins_o.addr[6], pins_o.addr[1], pins_o.addr[0]} == cfg_ff[6:4])
    else $error("autoselect pins wrong");
  a_verify_group_addr: assert property (op_ff == flash_host_pkg::op_verify && !pins_o.oe_n
    |-> pins_o.addr[20:12] == grp_bits && pins_o.addr[1:0] == 2'b10)
    else $error("verify address wrong");
  a_unprotect_guard: assert property (state_ff == flash_host_pkg::st_active && op_ff == flash_host_pkg::op_unprotect
    |-> &prot_ff)
    else $error("unprotect with a group unprotected");
  a_protect_high_volt: assert property (!pins_o.we_n && (op_ff == flash_host_pkg::op_protect
    || op_ff == flash_host_pkg::op_unprotect) |-> pins_o.hv_reset != pins_o.hv_oe)
    else $error("protect write without high voltage");
  a_prog_method_pins: assert property (pins_o.hv_oe |-> pins_o.hv_a9 && pins_o.oe_n)
    else $error("programmer method pins wrong");
  a_limit_reset_cmd: assert property ($rose(rst_pend_ff) |-> ##[1:12] (!pins_o.we_n && dq_o[7:0] == RESET_CMD[7:0]))
    else $error("reset command not written after limit flag");
  a_byte_mode_float: assert property (!pins_o.byte_n |-> &dq_oe_n_o[14:8] && !dq_oe_n_o[15])
    else $error("byte mode upper pins wrong");

  c_read_done: cover property (capture && op_ff == flash_host_pkg::op_read);
  c_verify_done: cover property (capture && op_ff == flash_host_pkg::op_verify);
  c_auto_reset: cover property (auto_launch);
  c_hw_reset: cover property ($rose(pins_o.reset_n));

endmodule : flash_host

// *** verif/flash_dev_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Behavioural flash device on the far side of the pins
// ****************************************************************
module flash_dev_model #(
  parameter bit TOP_BOOT = 1'b1,
  parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value.
  parameter logic [15:0] DEVICE_CODE = 16'h2b3c // Arbitrary value.
) (
  input wire logic clock_i,
  input wire flash_host_pkg::pins_s pins_i,
  input wire logic [15:0] dq_i,
  input wire logic [15:0] dq_oe_n_i,
  output logic [15:0] wire_o,
  output logic [23:0] prot_o,
  output logic [15:0] wr_data_o,
  output logic [20:0] wr_addr_o,
  output int wr_cnt_o,
  output int rst_low_o
);
  logic [15:0] q;
  logic [15:0] last = 16'h0000;
  logic drv;
  logic pwe = 1'b1;
  logic cmd_id = 1'b0;
  int run = 0;

  // Group from address bits 20..12, for the boot variant chosen by the parameter.
  function automatic logic [4:0] grp(input logic [8:0] s);
    if (TOP_BOOT) begin
      if (s[8:5] != 4'hf) return {1'b0, s[8:5]};
      if (s[4:3] == 2'b11) return 5'h10 + {2'h0, s[2:0]};
      return 5'h0f;
    end
    if (s[8:5] != 4'h0) return 5'h08 + {1'b0, s[8:5]};
    if (s[4:3] != 2'b00) return 5'h08;
    return {2'h0, s[2:0]};
  endfunction : grp

  // Array data is a pattern of the address, so every read needs no command first.
  // Any address is answered at once, so a sleeping device never needs a wake-up action.
  always_comb begin
    drv = pins_i.reset_n & ~pins_i.ce_n & ~pins_i.oe_n & pins_i.we_n;
    q = {~pins_i.addr[7:0], pins_i.addr[7:0]};
    if ((pins_i.hv_a9 || cmd_id) && pins_i.addr[1]) begin
      q = {15'h0000, prot_o[grp(pins_i.addr[20:12])]};
    end else if (pins_i.hv_a9 || cmd_id) begin
      q = pins_i.addr[0] ? DEVICE_CODE : MAKER_CODE;
    end
  end

  // Undriven bits show the inverse of their last level, so a stale value never passes as fresh.
  always_comb begin
    for (int b = 0; b < 16; b++) begin
      wire_o[b] = !dq_oe_n_i[b] ? dq_i[b] : (drv && (b < 8 || pins_i.byte_n)) ? q[b] : ~last[b];
    end
  end

  initial begin
    prot_o = 24'h00_0000;
    wr_cnt_o = 0;
    rst_low_o = 0;
  end

  // Write cycles are taken at the rising write strobe; reset pulses are measured.
  always @(posedge clock_i) begin
    last <= wire_o;
    pwe <= pins_i.we_n;
    if (pins_i.we_n && !pwe && !pins_i.ce_n && pins_i.oe_n) begin
      if ((pins_i.hv_reset || (pins_i.hv_a9 && pins_i.hv_oe)) && pins_i.addr[1:0] == 2'b10) begin
        if (pins_i.addr[6]) prot_o <= 24'h00_0000;
        else prot_o[grp(pins_i.addr[20:12])] <= 1'b1;
      end else begin
        wr_cnt_o <= wr_cnt_o + 1;
        wr_data_o <= wire_o;
        wr_addr_o <= pins_i.addr;
        if (wire_o == 16'h0090) cmd_id <= 1'b1;
        else if (wire_o == 16'h00f0) cmd_id <= 1'b0;
      end
    end
    if (!pins_i.reset_n) begin
      run <= run + 1;
      cmd_id <= 1'b0;
    end else if (run != 0) begin
      rst_low_o <= run;
      run <= 0;
    end
  end
endmodule : flash_dev_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected at %0t: got %0h want %0h", $time, (got), (exp)); end end
// ****************************************************************
// Register-level regression of the flash host controller
// ****************************************************************
module tb_top;
  localparam bit TOP_BOOT = 1'b1; // One boot variant for both sides
  localparam logic [15:0] MAKER_CODE = 16'h00a5; // Arbitrary value.
  localparam logic [15:0] DEVICE_CODE = 16'h2b3c; // Arbitrary value.
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] sw_addr_i = 8'h00;
  logic [31:0] sw_wdata_i = 32'h0000_0000;
  logic sw_wr_i = 1'b0;
  logic sw_rd_i = 1'b0;
  logic [31:0] sw_rdata_o, rv, st;
  flash_host_pkg::pins_s pins_o;
  logic [15:0] dq_i, dq_o, dq_oe_n_o, wr_data;
  logic [23:0] prot, mask;
  logic [20:0] wr_addr;
  logic [31:0] bad [3] = '{32'h0000_0007, 32'h0000_1804, 32'h0000_0006};
  int wr_cnt, rst_low, n, n0;
  int fails = 0;
  int tests_run = 0;

  always #2 clock_i = ~clock_i;

  flash_host #(.TOP_BOOT(TOP_BOOT)) flash_host_i (.clock_i(clock_i), .reset_i(reset_i), .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
    .pins_o(pins_o), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o));
  flash_dev_model #(.TOP_BOOT(TOP_BOOT), .MAKER_CODE(MAKER_CODE), .DEVICE_CODE(DEVICE_CODE)) flash_dev_model_i (
    .clock_i(clock_i), .pins_i(pins_o), .dq_i(dq_o), .dq_oe_n_i(dq_oe_n_o), .wire_o(dq_i),
    .prot_o(prot), .wr_data_o(wr_data), .wr_addr_o(wr_addr), .wr_cnt_o(wr_cnt), .rst_low_o(rst_low));

  // Each access leaves a free edge first, so a strobe is never lowered and raised in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge clock_i);
    sw_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge clock_i);
    sw_rd_i <= 1'b0;
    #1 rv = sw_rdata_o;
  endtask : rd

  // Start one operation, poll for done under a bound, keep the status and clear it.
  task automatic op(input logic [2:0] code, input logic [4:0] g);
    wr(flash_host_pkg::REG_CTRL, {19'h0_0000, g, 5'h00, code});
    n = 0;
    do begin
      rd(flash_host_pkg::REG_STATUS);
      n++;
    end while (rv[flash_host_pkg::ST_DONE] !== 1'b1 && n < 500);
    `CHK(n < 500, 1'b1)
    st = rv;
    wr(flash_host_pkg::REG_STATUS, 32'h0000_000e);
  endtask : op

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  // Main sequence of scenarios.
  initial begin
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    rd(flash_host_pkg::REG_STATUS);
    `CHK(rv, 32'h0000_0000)
    rd(8'h40);
    `CHK(rv, 32'h0000_0000)
    for (int i = 0; i < 2; i++) begin
      wr(flash_host_pkg::REG_ADDR, i ? 32'h0001_2311 : 32'h0001_2344);
      op(3'h0, 5'h00);
      rd(flash_host_pkg::REG_RDATA);
      `CHK(rv, i ? 32'h0000_ee11 : 32'h0000_bb44)
    end
    wr(flash_host_pkg::REG_CFG, 32'h0000_0001);
    wr(flash_host_pkg::REG_ADDR, 32'h0000_0089);
    op(3'h0, 5'h00);
    rd(flash_host_pkg::REG_RDATA);
    `CHK(rv, 32'h0000_0044)
    wr(flash_host_pkg::REG_CFG, 32'h0000_0000);
    wr(flash_host_pkg::REG_ADDR, 32'h0000_0155);
    wr(flash_host_pkg::REG_WDATA, 32'h0000_a5c3);
    op(3'h1, 5'h00);
    `CHK(wr_data, 16'ha5c3)
    `CHK(wr_addr, 21'h00_0155)
    // Identification by command, then the reset command to leave it again.
    wr(flash_host_pkg::REG_WDATA, 32'h0000_0090);
    op(3'h1, 5'h00);
    wr(flash_host_pkg::REG_ADDR, 32'h0000_0001);
    op(3'h0, 5'h00);
    rd(flash_host_pkg::REG_RDATA);
    `CHK(rv[15:0], DEVICE_CODE)
    wr(flash_host_pkg::REG_WDATA, 32'h0000_00f0);
    op(3'h1, 5'h00);
    `CHK(wr_data, flash_host_pkg::RESET_CMD_DEFAULT)
    op(3'h0, 5'h00);
    rd(flash_host_pkg::REG_RDATA);
    `CHK(rv, 32'h0000_fe01)
    op(3'h2, 5'h00);
    `CHK(rst_low, flash_host_pkg::RP_CYC + 1)
    for (int c = 0; c < 2; c++) begin
      wr(flash_host_pkg::REG_CFG, c ? 32'h0000_0010 : 32'h0000_0000);
      op(3'h3, 5'h00);
      rd(flash_host_pkg::REG_RDATA);
      `CHK(rv[15:0], c ? DEVICE_CODE : MAKER_CODE)
    end
    foreach (bad[i]) begin
      wr(flash_host_pkg::REG_CTRL, bad[i]);
      rd(flash_host_pkg::REG_STATUS);
      `CHK(rv[flash_host_pkg::ST_REFUSED], 1'b1)
      wr(flash_host_pkg::REG_STATUS, 32'h0000_000e);
    end
    mask = 24'h00_0000;
    for (int g = 0; g < 24; g++) begin
      mask[g] = 1'b1;
      op(3'h5, g[4:0]);
      `CHK(prot, mask)
      op(3'h4, g[4:0]);
      rd(flash_host_pkg::REG_PROT);
      `CHK(rv[23:0], mask)
    end
    op(3'h6, 5'h00);
    `CHK(prot, 24'h00_0000)
    wr(flash_host_pkg::REG_CFG, 32'h0000_0002);
    wr(flash_host_pkg::REG_ADDR, 32'h0000_0020);
    n0 = wr_cnt;
    op(3'h0, 5'h00);
    `CHK(st[flash_host_pkg::ST_LIMIT], 1'b1)
    repeat (40) @(posedge clock_i);
    `CHK(wr_cnt, n0 + 1)
    `CHK(wr_data, flash_host_pkg::RESET_CMD_DEFAULT)
    end_sim;
  end

  // Watchdog well beyond the expected length of the run.
  initial begin
    repeat (60000) @(posedge clock_i);
    fails++;
    end_sim;
  end
endmodule : tb_top
